// >>> rtl/hbc_ee_if.sv
// Link between the register bank and its EEPROM preload engine
interface hbc_ee_if;
	logic start;
	logic done;
	logic wordValid;
	logic [5:0] wordAddr;
	logic [15:0] wordData;
	logic eeCs;
	logic eeSk;
	logic eeDo;
	logic eeDi;

	modport loader (input start, input eeDi, output done, output wordValid, output wordAddr,
		output wordData, output eeCs, output eeSk, output eeDo);
	modport regs (output start, output eeDi, input done, input wordValid, input wordAddr,
		input wordData, input eeCs, input eeSk, input eeDo);
endinterface : hbc_ee_if

// >>> rtl/hbc_eeprom_loader.sv
// Serial EEPROM reader that fetches the station address words and the configuration word
`include "hbc_params.svh"

module hbc_eeprom_loader #(
	parameter int SK_HALF = `HBC_SK_HALF_CYC
) (
	input wire logic clk, // 200 MHz clock
	input wire logic rstn, // Async reset, active low
	hbc_ee_if.loader ee // Start, words out, EEPROM pins
);
	import hbc_pkg::*;

	// Two-flop data synchroniser needs three cycles of settle before the falling edge
	if (SK_HALF < 3 || SK_HALF > 1023) begin : gBadHalf
		$error("SK_HALF must lie in 3..1023");
	end

	localparam logic [9:0] HALF_LAST = 10'(SK_HALF - 1);

	hbc_ld_t q;
	hbc_ld_t d;

	// Fixed fetch order: three address words, then the config word
	function automatic logic [5:0] wordAddrOf(input logic [1:0] n);
		case (n)
			2'h0: wordAddrOf = `HBC_EE_MACL;
			2'h1: wordAddrOf = `HBC_EE_MACM;
			2'h2: wordAddrOf = `HBC_EE_MACH;
			default: wordAddrOf = `HBC_EE_CFG;
		endcase
	endfunction : wordAddrOf

	// Start bit, read opcode and address, MSB first, then zeros
	function automatic logic cmdBit(input logic [5:0] a, input logic [4:0] idx);
		logic [8:0] cmd;
		cmd = {`HBC_EE_READ_OP, a};
		if (idx > `HBC_EE_CMD_LAST)
			cmdBit = 1'b0;
		else
			cmdBit = cmd[4'(`HBC_EE_CMD_LAST - idx)];
	endfunction : cmdBit

	always_comb
	begin
		d = q;
		d.valid = 1'b0;
		d.di1 = ee.eeDi;
		d.di2 = q.di1;
		case (q.state)
			LD_IDLE:
			begin
				if (ee.start)
				begin
					d.state = LD_SHIFT;
					d.wordNum = 2'h0;
					d.addr = wordAddrOf(2'h0);
					d.cs = 1'b1;
					d.sk = 1'b0;
					d.div = 10'h000;
					d.bitCnt = 5'h00;
					d.dout = cmdBit(wordAddrOf(2'h0), 5'h00);
				end
			end
			LD_SHIFT:
			begin
				if (q.div == HALF_LAST)
				begin
					d.div = 10'h000;
					d.sk = !q.sk;
					if (q.sk)
					begin
						if (q.bitCnt >= `HBC_EE_DATA_FIRST)
							d.shift = {q.shift[14:0], q.di2};
						if (q.bitCnt == `HBC_EE_LAST_BIT)
						begin
							d.state = LD_GAP;
							d.cs = 1'b0;
							d.dout = 1'b0;
							d.valid = 1'b1; // RULE_08
						end
						else
						begin
							d.bitCnt = q.bitCnt + 5'h01;
							d.dout = cmdBit(q.addr, q.bitCnt + 5'h01);
						end
					end
				end
				else
					d.div = q.div + 10'h001;
			end
			LD_GAP:
			begin
				if (q.div == HALF_LAST)
				begin
					d.div = 10'h000;
					if (q.wordNum == `HBC_EE_WORDS_LAST)
					begin
						d.state = LD_DONE;
						d.done = 1'b1;
					end
					else
					begin
						d.state = LD_SHIFT;
						d.wordNum = q.wordNum + 2'h1;
						d.addr = wordAddrOf(q.wordNum + 2'h1);
						d.cs = 1'b1;
						d.bitCnt = 5'h00;
						d.dout = cmdBit(wordAddrOf(q.wordNum + 2'h1), 5'h00);
					end
				end
				else
					d.div = q.div + 10'h001;
			end
			LD_DONE: d.done = 1'b1;
			default: d.state = LD_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			q <= '{state: LD_IDLE, default: '0};
		else
			q <= d;
	end

	assign ee.done = q.done;
	assign ee.wordValid = q.valid;
	assign ee.wordAddr = q.addr;
	assign ee.wordData = q.shift;
	assign ee.eeCs = q.cs;
	assign ee.eeSk = q.sk;
	assign ee.eeDo = q.dout;

	AST_LD_SK_LOW_IDLE: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
		!q.cs && q.state != LD_GAP |-> !q.sk)
		else $error("Serial clock toggles with chip select low");

endmodule : hbc_eeprom_loader

// >>> rtl/hbc_params.svh
// Offsets, field positions, reset values and timing of the host bus config registers
// How it works
// [RULE_01] Bit 12 of rx_watermark_config picks the receive high watermark: 0 is 3 KB, 1 is 2 KB, reset 0.
// [RULE_02] An access with an illegal byte-enable set raises illegal_lane_flag at bit 15; writing 1 clears it.
// [RULE_03] The offending byte-enable pattern is kept in bits 14..11, lane 3 at bit 14, valid while the flag is up.
// [RULE_04] Synchronous and asynchronous transfers at once raise mixed_transfer_flag at bit 10; writing 1 clears it.
// [RULE_05] burst_length_field in bits 14..12 decodes 000 single, 011 four, 101 eight, 111 sixteen; reset 000.
// [RULE_06] The host programs the burst length before it starts any burst transfer.
// [RULE_07] Every location of bank 1 is reserved except the bank selector at offset 0xE.
// [RULE_08] With the EEPROM in use, reset loads the three station address words from EEPROM words 1 onward.
// [RULE_09] EEPROM word 1 goes to the low, word 2 to the middle and word 3 to the high station address word.
// [RULE_10] Software may rewrite the station address at any time and such writes never touch the EEPROM.
// [RULE_11] bus_speed_field in bits 1..0 sets the internal bus to 125, 62.5, 41.66 or 25 MHz for 00..11.
// [RULE_12] Without an EEPROM the bus speed field leaves reset at 00, the fastest rate.
// [RULE_13] With the EEPROM, bit 1 of configuration word 6 loads the speed field as 00 or 11.
// [RULE_14] After the EEPROM load, software writes to the speed field still take effect.
// [RULE_15] A six-bit bank_selector at offset 0xE picks the bank and is reachable from every bank.
// [RULE_16] The EEPROM load runs after reset only if eeprom_enable_input is high; otherwise defaults stay.
// [RULE_17] Reserved bits read as zero and writes to them have no effect on the writable fields.
`ifndef HBC_PARAMS_SVH
`define HBC_PARAMS_SVH

`define HBC_OFS_MACL 4'h0
`define HBC_OFS_MACM 4'h2
`define HBC_OFS_MACH 4'h4
`define HBC_OFS_SPEED 4'h0
`define HBC_OFS_RXWM 4'h4
`define HBC_OFS_BERR 4'h6
`define HBC_OFS_BURST 4'h8
`define HBC_OFS_BANK 4'hE

`define HBC_BANK_CFG 6'h00
`define HBC_BANK_RSVD 6'h01
`define HBC_BANK_MAC 6'h02
`define HBC_BANK_CTL 6'h03

`define HBC_WM_BIT 12
`define HBC_ILL_BIT 15
`define HBC_PAT_HI 14
`define HBC_PAT_LO 11
`define HBC_MIX_BIT 10
`define HBC_BRL_HI 14
`define HBC_BRL_LO 12
`define HBC_SPD_HI 1
`define HBC_BANK_HI 5

`define HBC_RST_BANK 6'h00
`define HBC_RST_WM 1'h0
`define HBC_RST_BRL 3'h0
`define HBC_RST_SPEED 2'h0
`define HBC_RST_MAC 16'h0000
`define HBC_RST_BEATS 5'h01

`define HBC_BRL_SINGLE 3'h0
`define HBC_BRL_4 3'h3
`define HBC_BRL_8 3'h5
`define HBC_BRL_16 3'h7
`define HBC_BEATS_4 5'h04
`define HBC_BEATS_8 5'h08
`define HBC_BEATS_16 5'h10

`define HBC_EE_MACL 6'h01
`define HBC_EE_MACM 6'h02
`define HBC_EE_MACH 6'h03
`define HBC_EE_CFG 6'h06
`define HBC_EE_SPD_BIT 1
`define HBC_EE_READ_OP 3'h6
`define HBC_EE_CMD_LAST 5'h08
`define HBC_EE_DATA_FIRST 5'h0A
`define HBC_EE_LAST_BIT 5'h19
`define HBC_EE_WORDS_LAST 2'h3

`define HBC_CLK_NS 5
`define HBC_SK_HALF_NS 500
`define HBC_SK_HALF_CYC ((`HBC_SK_HALF_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_STRAP_WAIT 2'h3

`endif

// >>> rtl/hbc_pkg.sv
// Types shared by the host bus config registers and the EEPROM loader
package hbc_pkg;

	typedef enum logic [3:0] {
		LD_IDLE = 4'b0001,
		LD_SHIFT = 4'b0010,
		LD_GAP = 4'b0100,
		LD_DONE = 4'b1000
	} hbc_ld_state_t;

	typedef struct packed {
		hbc_ld_state_t state;
		logic [9:0] div;
		logic sk;
		logic cs;
		logic dout;
		logic [4:0] bitCnt;
		logic [1:0] wordNum;
		logic [5:0] addr;
		logic [15:0] shift;
		logic di1;
		logic di2;
		logic valid;
		logic done;
	} hbc_ld_t;

	typedef struct packed {
		logic strap1;
		logic strap2;
		logic [1:0] strapCnt;
		logic strapSeen;
		logic loadStart;
		logic loadDone;
		logic [5:0] bank;
		logic wm;
		logic illFlag;
		logic [3:0] illPat;
		logic mixFlag;
		logic [2:0] burst_length_field;
		logic [4:0] beats;
		logic [15:0] macL;
		logic [15:0] macM;
		logic [15:0] macH;
		logic [1:0] speed;
		logic [15:0] rdData;
		logic rdValid;
	} hbc_reg_t;

endpackage : hbc_pkg

// >>> rtl/hbc_regs.sv
// Banked host bus configuration and status registers with EEPROM preload
`include "hbc_params.svh"

module hbc_regs #(
	parameter int SK_HALF = `HBC_SK_HALF_CYC
) (
	input wire logic clk, // 200 MHz clock
	input wire logic rstn, // Async reset, active low
	input wire logic [3:0] hostAddr, // Byte offset of 16-bit register
	input wire logic hostRd, // Read strobe, one cycle
	input wire logic hostWr, // Write strobe, one cycle
	input wire logic [3:0] hostBe, // Byte enables, lane 3 to 0
	input wire logic [15:0] hostWdata, // Write data
	input wire logic syncXfer, // Synchronous transfer active
	input wire logic asyncXfer, // Asynchronous transfer active
	input wire logic eeEnable, // EEPROM strap pin
	input wire logic eeDi, // EEPROM serial data in
	output logic [15:0] hostRdata, // Read data
	output logic hostRdValid, // Read data valid, one cycle
	output logic rxWatermarkTwoKb, // High watermark 2 KB when set
	output logic [4:0] burstBeats, // Beats per burst
	output logic [1:0] busSpeed, // Internal bus speed code
	output logic [47:0] stationAddr, // Station address
	output logic [5:0] bankSelect, // Current bank
	output logic eeLoadDone, // Preload finished or skipped
	output logic eeCs, // EEPROM chip select
	output logic eeSk, // EEPROM serial clock
	output logic eeDo // EEPROM serial data out
);
	import hbc_pkg::*;

	if (SK_HALF < 3 || SK_HALF > 1023) begin : gBadHalf
		$error("SK_HALF must lie in 3..1023");
	end

	hbc_reg_t q;
	hbc_reg_t d;
	hbc_ee_if eeBus ();

	logic access;
	logic illegal;
	logic laneLo;
	logic laneHi;
	logic [3:0] regOfs;
	logic [15:0] mergedWr;

	function automatic logic beLegal(input logic [3:0] be);
		case (be)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: beLegal = 1'b1;
			default: beLegal = 1'b0;
		endcase
	endfunction : beLegal

	function automatic logic [4:0] beatsOf(input logic [2:0] burst_length_field);
		case (burst_length_field)
			`HBC_BRL_4: beatsOf = `HBC_BEATS_4;
			`HBC_BRL_8: beatsOf = `HBC_BEATS_8;
			`HBC_BRL_16: beatsOf = `HBC_BEATS_16;
			default: beatsOf = `HBC_RST_BEATS;
		endcase
	endfunction : beatsOf

	// Read view; unmapped banks and reserved bits give zero
	function automatic logic [15:0] regRead(input hbc_reg_t s, input logic [3:0] a);
		logic [15:0] r;
		r = 16'h0000;
		if (a == `HBC_OFS_BANK)
			r[`HBC_BANK_HI:0] = s.bank; // RULE_15
		else
		begin
			case (s.bank)
				`HBC_BANK_CFG:
				begin
					case (a)
						`HBC_OFS_RXWM: r[`HBC_WM_BIT] = s.wm; // RULE_17
						`HBC_OFS_BERR:
						begin
							r[`HBC_ILL_BIT] = s.illFlag;
							r[`HBC_PAT_HI:`HBC_PAT_LO] = s.illPat;
							r[`HBC_MIX_BIT] = s.mixFlag;
						end
						`HBC_OFS_BURST: r[`HBC_BRL_HI:`HBC_BRL_LO] = s.burst_length_field;
						default: r = 16'h0000;
					endcase
				end
				`HBC_BANK_MAC:
				begin
					case (a)
						`HBC_OFS_MACL: r = s.macL;
						`HBC_OFS_MACM: r = s.macM;
						`HBC_OFS_MACH: r = s.macH;
						default: r = 16'h0000;
					endcase
				end
				`HBC_BANK_CTL:
				begin
					if (a == `HBC_OFS_SPEED)
						r[`HBC_SPD_HI:0] = s.speed;
				end
				default: r = 16'h0000; // RULE_07
			endcase
		end
		regRead = r;
	endfunction : regRead

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic lo, input logic hi);
		merge16 = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
	endfunction : merge16

	always_comb
	begin
		regOfs = {hostAddr[3:1], 1'b0};
		access = hostRd || hostWr;
		illegal = access && !beLegal(hostBe);
		laneLo = hostBe[{hostAddr[1], 1'b0}];
		laneHi = hostBe[{hostAddr[1], 1'b1}];
		mergedWr = merge16(regRead(q, regOfs), hostWdata, laneLo, laneHi);
	end

	always_comb
	begin
		d = q;
		d.rdValid = 1'b0;
		d.loadStart = 1'b0;
		d.strap1 = eeEnable;
		d.strap2 = q.strap1;
		// Strap is sampled once, after the synchroniser has filled
		if (!q.strapSeen)
		begin
			if (q.strapCnt == `HBC_STRAP_WAIT)
			begin
				d.strapSeen = 1'b1;
				d.loadStart = q.strap2; // RULE_16
				d.loadDone = !q.strap2;
			end
			else
				d.strapCnt = q.strapCnt + 2'h1;
		end
		if (eeBus.done)
			d.loadDone = 1'b1;
		if (eeBus.wordValid)
		begin
			case (eeBus.wordAddr)
				`HBC_EE_MACL: d.macL = eeBus.wordData; // RULE_09
				`HBC_EE_MACM: d.macM = eeBus.wordData; // RULE_09
				`HBC_EE_MACH: d.macH = eeBus.wordData; // RULE_09
				`HBC_EE_CFG: d.speed = {2{eeBus.wordData[`HBC_EE_SPD_BIT]}}; // RULE_13
				default: d.speed = d.speed;
			endcase
		end
		if (hostRd)
		begin
			d.rdValid = 1'b1;
			d.rdData = regRead(q, regOfs);
		end
		// Writes with illegal lanes are dropped; software wins over preload
		if (hostWr && !illegal)
		begin
			if (regOfs == `HBC_OFS_BANK)
			begin
				if (laneLo)
					d.bank = hostWdata[`HBC_BANK_HI:0]; // RULE_15
			end
			else
			begin
				case (q.bank)
					`HBC_BANK_CFG:
					begin
						case (regOfs)
							`HBC_OFS_RXWM: d.wm = mergedWr[`HBC_WM_BIT]; // RULE_01
							`HBC_OFS_BERR:
							begin
								if (laneHi && hostWdata[`HBC_ILL_BIT])
									d.illFlag = 1'b0; // RULE_02
								if (laneHi && hostWdata[`HBC_MIX_BIT])
									d.mixFlag = 1'b0; // RULE_04
							end
							`HBC_OFS_BURST: d.burst_length_field = mergedWr[`HBC_BRL_HI:`HBC_BRL_LO]; // RULE_05
							default: d.burst_length_field = d.burst_length_field;
						endcase
					end
					`HBC_BANK_MAC:
					begin
						case (regOfs)
							`HBC_OFS_MACL: d.macL = mergedWr; // RULE_10
							`HBC_OFS_MACM: d.macM = mergedWr; // RULE_10
							`HBC_OFS_MACH: d.macH = mergedWr; // RULE_10
							default: d.macL = d.macL;
						endcase
					end
					`HBC_BANK_CTL:
					begin
						if (regOfs == `HBC_OFS_SPEED)
							d.speed = mergedWr[`HBC_SPD_HI:0]; // RULE_14
					end
					default: d.bank = d.bank; // RULE_07
				endcase
			end
		end
		// Hardware set comes last so it wins over a same-cycle clear
		if (illegal)
		begin
			d.illFlag = 1'b1; // RULE_02
			d.illPat = hostBe; // RULE_03
		end
		if (syncXfer && asyncXfer)
			d.mixFlag = 1'b1; // RULE_04
		d.beats = beatsOf(d.burst_length_field); // RULE_05
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.bank <= `HBC_RST_BANK;
			q.wm <= `HBC_RST_WM; // RULE_01
			q.burst_length_field <= `HBC_RST_BRL;
			q.beats <= `HBC_RST_BEATS;
			q.speed <= `HBC_RST_SPEED; // RULE_12
			q.macL <= `HBC_RST_MAC;
			q.macM <= `HBC_RST_MAC;
			q.macH <= `HBC_RST_MAC;
		end
		else
			q <= d;
	end

	hbc_eeprom_loader #(
		.SK_HALF(SK_HALF)
	) uLoader (
		.clk(clk),
		.rstn(rstn),
		.ee(eeBus)
	);

	assign eeBus.start = q.loadStart; // RULE_08
	assign eeBus.eeDi = eeDi;
	assign hostRdata = q.rdData;
	assign hostRdValid = q.rdValid;
	assign rxWatermarkTwoKb = q.wm;
	assign burstBeats = q.beats;
	assign busSpeed = q.speed; // RULE_11
	assign stationAddr = {q.macH, q.macM, q.macL};
	assign bankSelect = q.bank;
	assign eeLoadDone = q.loadDone;
	assign eeCs = eeBus.eeCs;
	assign eeSk = eeBus.eeSk;
	assign eeDo = eeBus.eeDo;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	AST_WMARK_WRITE: assert property ( // RULE_01
		hostWr && !illegal && q.bank == `HBC_BANK_CFG && regOfs == `HBC_OFS_RXWM && laneHi
		|=> rxWatermarkTwoKb == $past(hostWdata[`HBC_WM_BIT]))
		else $error("Watermark bit not taken from write");

	AST_ILLEGAL_CAPTURE: assert property ( // RULE_02
		illegal |=> q.illFlag && q.illPat == $past(hostBe)) // RULE_03
		else $error("Illegal lanes not flagged or captured");

	AST_ILLEGAL_W1C: assert property ( // RULE_02
		hostWr && !illegal && q.bank == `HBC_BANK_CFG && regOfs == `HBC_OFS_BERR && laneHi
		&& hostWdata[`HBC_ILL_BIT] |=> !q.illFlag)
		else $error("Illegal lane flag not cleared by write of one");

	AST_MIXED_SET: assert property ( // RULE_04
		syncXfer && asyncXfer |=> q.mixFlag [*1] ##1 (q.mixFlag || $past(hostWr)))
		else $error("Mixed transfer flag not raised");

	AST_BURST_DECODE: assert property ( // RULE_05
		hostWr && !illegal && q.bank == `HBC_BANK_CFG && regOfs == `HBC_OFS_BURST && laneHi
		&& hostWdata[`HBC_BRL_HI:`HBC_BRL_LO] == `HBC_BRL_16 |=> burstBeats == `HBC_BEATS_16)
		else $error("Burst of sixteen not decoded");

	AST_BANK1_ZERO: assert property ( // RULE_07
		hostRd && q.bank == `HBC_BANK_RSVD && regOfs != `HBC_OFS_BANK
		|=> hostRdValid && hostRdata == 16'h0000)
		else $error("Reserved bank read is not zero");

	AST_BANK_ANY: assert property ( // RULE_15
		hostWr && !illegal && regOfs == `HBC_OFS_BANK && laneLo
		|=> bankSelect == $past(hostWdata[`HBC_BANK_HI:0]))
		else $error("Bank selector not written");

	AST_MAC_PRELOAD: assert property ( // RULE_09
		eeBus.wordValid && eeBus.wordAddr == `HBC_EE_MACM && !hostWr
		|=> stationAddr[31:16] == $past(eeBus.wordData))
		else $error("Middle address word not preloaded");

	AST_SPEED_PRELOAD: assert property ( // RULE_13
		eeBus.wordValid && eeBus.wordAddr == `HBC_EE_CFG && !hostWr
		|=> busSpeed == {2{$past(eeBus.wordData[`HBC_EE_SPD_BIT])}})
		else $error("Speed field not loaded from config word");

	AST_NO_STRAP_NO_LOAD: assert property ( // RULE_16
		eeLoadDone |-> !eeCs && !eeBus.start)
		else $error("EEPROM accessed after load done or with strap low");

	AST_RESERVED_ZERO: assert property ( // RULE_17
		hostRd && q.bank == `HBC_BANK_CFG && regOfs == `HBC_OFS_RXWM
		|=> (hostRdata & 16'hEFFF) == 16'h0000)
		else $error("Reserved bits read non-zero");

	COV_PRELOAD_DONE: cover property ($rose(eeLoadDone) && eeCs == 1'b0);
	COV_ILLEGAL_AND_CLEAR: cover property (q.illFlag ##[1:20] !q.illFlag);
	COV_SPEED_REWRITE: cover property (eeLoadDone && $changed(busSpeed));

endmodule : hbc_regs

// >>> verif/hbc_ee_model.sv
// Behavioural serial EEPROM answering the preload reads
module hbc_ee_model (
	input wire logic eeCs, // Chip select from device
	input wire logic eeSk, // Serial clock from device
	input wire logic eeDo, // Command bits from device
	output logic eeDi, // Data bits to device
	input wire logic [15:0] word1, // Word 1 contents
	input wire logic [15:0] word2, // Word 2 contents
	input wire logic [15:0] word3, // Word 3 contents
	input wire logic [15:0] word6 // Word 6 contents
);
	timeunit 1ns;
	timeprecision 1ps;
	int n;
	logic [8:0] cmd;
	logic [15:0] w;
	function automatic logic [15:0] pick(input logic [5:0] a);
		case (a)
			6'h01: pick = word1;
			6'h02: pick = word2;
			6'h03: pick = word3;
			6'h06: pick = word6;
			default: pick = 16'hFFFF;
		endcase
	endfunction : pick
	initial
	begin
		n = 0;
		cmd = '0;
		w = '0;
		eeDi = 1'b0;
	end
	always @(posedge eeSk or negedge eeCs)
	begin
		if (!eeCs)
		begin
			n = 0;
			eeDi = ~eeDi; // Released: inverse of last bit
		end
		else
		begin
			if (n < 9)
				cmd = {cmd[7:0], eeDo};
			if (n == 9)
			begin
				w = pick(cmd[5:0]);
				eeDi = (cmd[8:6] == 3'h6) ? 1'b0 : 1'b1; // Dummy zero only for a read
			end
			else if (n > 9 && n < 26)
				eeDi = w[25 - n];
			n = n + 1;
		end
	end
endmodule : hbc_ee_model

// >>> verif/tb_top.sv
// Self-checking bench for the host bus config registers
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import hbc_pkg::*;
	logic clk, rstn, hostRd, hostWr, syncXfer, asyncXfer, eeEnable, eeDi;
	logic [3:0] hostAddr, hostBe;
	logic [15:0] hostWdata, hostRdata, v;
	logic hostRdValid, rxWatermarkTwoKb, eeLoadDone, eeCs, eeSk, eeDo;
	logic [4:0] burstBeats;
	logic [1:0] busSpeed;
	logic [47:0] stationAddr;
	logic [5:0] bankSelect;
	logic [15:0] word [4];
	logic [15:0] mac [3];
	logic [31:0] expQ [$];
	logic [31:0] e;
	int errors, compares, seed;
	logic [2:0] codes [5] = '{3'h0, 3'h3, 3'h5, 3'h7, 3'h1};
	logic [4:0] beats [5] = '{5'h01, 5'h04, 5'h08, 5'h10, 5'h01};
	logic [3:0] badBe [3] = '{4'h5, 4'hA, 4'h7};
	hbc_regs #(.SK_HALF(3)) u_hbc_regs (.clk(clk), .rstn(rstn), .hostAddr(hostAddr),
		.hostRd(hostRd), .hostWr(hostWr), .hostBe(hostBe), .hostWdata(hostWdata),
		.syncXfer(syncXfer), .asyncXfer(asyncXfer), .eeEnable(eeEnable), .eeDi(eeDi),
		.hostRdata(hostRdata), .hostRdValid(hostRdValid), .rxWatermarkTwoKb(rxWatermarkTwoKb),
		.burstBeats(burstBeats), .busSpeed(busSpeed), .stationAddr(stationAddr),
		.bankSelect(bankSelect), .eeLoadDone(eeLoadDone), .eeCs(eeCs), .eeSk(eeSk), .eeDo(eeDo));
	hbc_ee_model u_hbc_ee_model (.eeCs(eeCs), .eeSk(eeSk), .eeDo(eeDo), .eeDi(eeDi),
		.word1(word[0]), .word2(word[1]), .word3(word[2]), .word6(word[3]));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d,
		input logic [3:0] be);
		@(posedge clk);
		hostAddr <= a;
		hostBe <= be;
		hostWdata <= d;
		hostWr <= w;
		hostRd <= ~w;
		@(posedge clk);
		hostWr <= 1'b0;
		hostRd <= 1'b0;
		@(negedge clk);
	endtask : acc
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		acc(1'b1, a, d, a[1] ? 4'hC : 4'h3);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m = 16'hFFFF);
		expQ.push_back({m, x});
		acc(1'b0, a, 16'h0000, a[1] ? 4'hC : 4'h3);
	endtask : rd
	task automatic xfer(input logic s, input logic a);
		@(posedge clk);
		syncXfer <= s;
		asyncXfer <= a;
		@(posedge clk);
		syncXfer <= 1'b0;
		asyncXfer <= 1'b0;
		@(negedge clk);
	endtask : xfer
	task automatic resetDut(input logic en);
		int i;
		@(posedge clk);
		rstn <= 1'b0;
		eeEnable <= en;
		repeat (12) @(posedge clk);
		check("burstBeats", 48'(burstBeats), 48'(5'h01));
		rstn <= 1'b1;
		i = 0;
		while (eeLoadDone !== 1'b1 && i < 4000)
		begin
			@(posedge clk);
			i++;
		end
		check("eeLoadDone", 48'(eeLoadDone), 48'(1'b1));
		@(negedge clk);
	endtask : resetDut
	always @(posedge clk)
	begin
		if (hostRdValid === 1'b1)
		begin
			if (expQ.size() == 0)
				check("hostRdValid", 48'(1'b1), 48'(1'b0));
			else
			begin
				e = expQ.pop_front();
				check("hostRdata", 48'(hostRdata & e[31:16]), 48'(e[15:0] & e[31:16]));
			end
		end
	end
	initial
	begin
		repeat (30000) @(posedge clk);
		errors++;
		stop_test();
	end
	initial
	begin
		errors = 0;
		compares = 0;
		seed = 16083;
		rstn = 1'b0;
		hostAddr = '0;
		hostBe = '0;
		hostWdata = '0;
		hostRd = 1'b0;
		hostWr = 1'b0;
		syncXfer = 1'b0;
		asyncXfer = 1'b0;
		eeEnable = 1'b1;
		for (int i = 0; i < 4; i++)
			word[i] = 16'($random(seed));
		word[3][1] = 1'b1;
		resetDut(1'b1);
		check("stationAddr", stationAddr, {word[2], word[1], word[0]});
		check("busSpeed", 48'(busSpeed), 48'(2'h3));
		wr(4'hE, 16'h0002);
		for (int i = 0; i < 3; i++)
			rd(4'(2 * i), word[i]);
		for (int i = 0; i < 3; i++)
		begin
			mac[i] = 16'($random(seed));
			wr(4'(2 * i), mac[i]);
		end
		check("stationAddr", stationAddr, {mac[2], mac[1], mac[0]});
		rd(4'h4, mac[2]);
		$display("test preload and address overwrite done");
		word[3][1] = 1'b0;
		resetDut(1'b1);
		check("stationAddr", stationAddr, {word[2], word[1], word[0]});
		check("busSpeed", 48'(busSpeed), 48'(2'h0));
		wr(4'hE, 16'h0003);
		for (int s = 0; s < 4; s++)
		begin
			v = 16'($random(seed));
			v[1:0] = 2'(s);
			wr(4'h0, v);
			check("busSpeed", 48'(busSpeed), 48'(v[1:0]));
			rd(4'h0, {14'h0000, v[1:0]});
		end
		$display("test bus speed done");
		wr(4'hE, 16'h0000);
		wr(4'h4, 16'hFFFF);
		check("rxWatermarkTwoKb", 48'(rxWatermarkTwoKb), 48'(1'b1));
		rd(4'h4, 16'h1000);
		wr(4'h4, 16'hEFFF);
		check("rxWatermarkTwoKb", 48'(rxWatermarkTwoKb), 48'(1'b0));
		for (int i = 0; i < 5; i++)
		begin
			wr(4'h8, {1'b1, codes[i], 12'hFFF});
			check("burstBeats", 48'(burstBeats), 48'(beats[i]));
			rd(4'h8, {1'b0, codes[i], 12'h000});
		end
		$display("test watermark and burst done");
		for (int i = 0; i < 3; i++)
		begin
			acc(1'b1, 4'h4, 16'hFFFF, badBe[i]);
			check("rxWatermarkTwoKb", 48'(rxWatermarkTwoKb), 48'(1'b0));
			rd(4'h6, {1'b1, badBe[i], 11'h000}, 16'hFC00);
			wr(4'h6, 16'h8000);
			rd(4'h6, 16'h0000, 16'h8000);
		end
		xfer(1'b1, 1'b0);
		xfer(1'b0, 1'b1);
		rd(4'h6, 16'h0000, 16'h0400);
		xfer(1'b1, 1'b1);
		rd(4'h6, 16'h0400, 16'h0400);
		wr(4'h6, 16'h0400);
		rd(4'h6, 16'h0000, 16'h0400);
		$display("test bus errors done");
		wr(4'hE, 16'hFFC1);
		check("bankSelect", 48'(bankSelect), 48'(6'h01));
		rd(4'hE, 16'h0001);
		rd(4'h4, 16'h0000);
		wr(4'h4, 16'hFFFF);
		check("rxWatermarkTwoKb", 48'(rxWatermarkTwoKb), 48'(1'b0));
		wr(4'hE, 16'h0000);
		rd(4'h4, 16'h0000);
		$display("test reserved bank done");
		resetDut(1'b0);
		check("stationAddr", stationAddr, 48'h0000_0000_0000);
		check("busSpeed", 48'(busSpeed), 48'(2'h0));
		check("eeCs", 48'(eeCs), 48'(1'b0));
		$display("test strap low done");
		repeat (4) @(posedge clk);
		check("pending reads", 48'(expQ.size()), 48'(0));
		stop_test();
	end
endmodule : tb_top
